// file: design/pss_status_regs.sv
`timescale 1ns/1ns
`default_nettype none
module pss_status_regs #(
  parameter int unsigned TICK_CYCLES_P = pss_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_oe,
  // Detection levels and rate select from the sensing engine
  input  wire logic        prox_detect,
  input  wire logic        touch_detect,
  input  wire logic        prox_raw_detect,
  input  wire logic        motion_detect,
  input  wire logic        fast_rate,
  // Calibration results, one-cycle pulses
  input  wire logic        prox_cal_fail,
  input  wire logic        prox_cal_pass,
  input  wire logic        motion_cal_fail,
  input  wire logic        motion_cal_pass,
  // Count values from the sensing engine
  input  wire logic [15:0] filtered_count,
  input  wire logic [15:0] long_average_reference,
  input  wire logic [15:0] quick_release_reference,
  input  wire logic [15:0] motion_filtered_count,
  input  wire logic [15:0] motion_upper_reference,
  input  wire logic [15:0] motion_lower_reference,
  // Device outputs
  output logic             prox_out_oe,
  output logic             prox_cal_retry,
  output logic             motion_cal_retry,
  output logic             stabilizing,
  output logic             test_mode_window
);
  import pss_pkg::*;

  // Millisecond prescaler
  logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic              tick_q, tick_d;

  // Timers
  logic [TMR_W-1:0]  tmr_val  [TMR_NUM];  // Load values
  logic [TMR_W-1:0]  tmr_cnt  [TMR_NUM];  // Current counts
  logic [TMR_NUM-1:0] tmr_load;           // Load strobes
  logic [TMR_NUM-1:0] tmr_exp;            // Expiry pulses

  // Status state
  logic started_q, started_d;             // Start-up timers armed
  logic prox_err_q, prox_err_d;           // Proximity calibration error
  logic mot_err_q, mot_err_d;             // Movement calibration error
  logic [7:0] flags_q, flags_d;           // Event flag byte
  logic prox_oe_q, prox_oe_d;             // Open-drain pull-down

  // Bus slave state
  pss_bus_state_t st_q, st_d;
  logic       scl_q, sda_q;               // Previous pin samples
  logic [2:0] bit_q, bit_d;               // Bit index within byte
  logic [7:0] shift_q, shift_d;           // Shift register
  logic [7:0] ptr_q, ptr_d;               // Register pointer
  logic       first_q, first_d;           // Next write byte is the pointer
  logic       rw_q, rw_d;                 // Read transfer
  logic       ack_q, ack_d;               // Host acked last read byte
  logic       clocked_q, clocked_d;       // A bit clocked in since start
  logic       oe_q, oe_d;                 // SDA pull-down
  logic       start_ev, stop_ev;          // Bus conditions
  logic       scl_rise, scl_fall;
  logic [7:0] rd_byte;                    // Read data mux

  // Prescaler
  always_comb begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + 17'h0_0001;
    if (tick_cnt_q == TICK_W'(TICK_CYCLES_P - 1)) begin
      tick_cnt_d = '0;
      tick_d     = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // One countdown per timer slot
  genvar gi;
  generate
    for (gi = 0; gi < TMR_NUM; gi++) begin : g_tmr
      pss_countdown u_cd (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .tick     (tick_q),
        .load     (tmr_load[gi]),
        .load_val (tmr_val[gi]),
        .count_q  (tmr_cnt[gi]),
        .expire_q (tmr_exp[gi])
      );
    end
  endgenerate

  // Timer loads and calibration error state
  always_comb begin
    started_d  = 1'b1;
    prox_err_d = prox_err_q;
    mot_err_d  = mot_err_q;
    tmr_load   = '0;
    tmr_val[TMR_PROX]   = TMR_W'(CAL_RETRY_MS);
    tmr_val[TMR_MOTION] = TMR_W'(CAL_RETRY_MS);
    tmr_val[TMR_TEST]   = TMR_W'(TEST_MODE_MS);
    // Window length picked from the rate at start-up
    tmr_val[TMR_STAB]   = fast_rate ? TMR_W'(STAB_FAST_MS) : TMR_W'(STAB_DEFAULT_MS);
    tmr_load[TMR_STAB]  = !started_q;
    tmr_load[TMR_TEST]  = !started_q || start_ev || stop_ev;
    // Pass clears, fail sets; a fail in the same cycle wins
    if (prox_cal_pass) begin
      prox_err_d = 1'b0;
      tmr_load[TMR_PROX] = 1'b1;
      tmr_val[TMR_PROX]  = TMR_RST;
    end
    if (prox_cal_fail || (prox_err_q && tmr_exp[TMR_PROX])) begin
      prox_err_d = 1'b1;
      tmr_load[TMR_PROX] = 1'b1;
      tmr_val[TMR_PROX]  = TMR_W'(CAL_RETRY_MS);
    end
    if (motion_cal_pass) begin
      mot_err_d = 1'b0;
      tmr_load[TMR_MOTION] = 1'b1;
      tmr_val[TMR_MOTION]  = TMR_RST;
    end
    if (motion_cal_fail || (mot_err_q && tmr_exp[TMR_MOTION])) begin
      mot_err_d = 1'b1;
      tmr_load[TMR_MOTION] = 1'b1;
      tmr_val[TMR_MOTION]  = TMR_W'(CAL_RETRY_MS);
    end
  end

  // Flag byte and output drive
  always_comb begin
    flags_d = BYTE_RST;
    // Detections are absorbed while the window runs
    if (!stabilizing) begin
      flags_d[BIT_PROX]   = prox_detect;
      flags_d[BIT_TOUCH]  = touch_detect;
      flags_d[BIT_RAW]    = prox_raw_detect;
      flags_d[BIT_MOTION] = motion_detect;
    end
    flags_d[BIT_PROX_CAL]   = prox_err_d;
    flags_d[BIT_MOTION_CAL] = mot_err_d;
    // Proximity calibration error forces the output active to fail safe
    prox_oe_d = flags_d[BIT_PROX] || prox_err_d;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      started_q  <= 1'b0;
      prox_err_q <= 1'b0;
      mot_err_q  <= 1'b0;
      flags_q    <= BYTE_RST;
      prox_oe_q  <= 1'b0;
    end else begin
      started_q  <= started_d;
      prox_err_q <= prox_err_d;
      mot_err_q  <= mot_err_d;
      flags_q    <= flags_d;
      prox_oe_q  <= prox_oe_d;
    end
  end

  // Pin only ever pulls low; a pull-up makes the high level
  assign prox_out_oe      = prox_oe_q;
  assign prox_cal_retry   = prox_err_q && tmr_exp[TMR_PROX];
  assign motion_cal_retry = mot_err_q && tmr_exp[TMR_MOTION];
  assign stabilizing      = !started_q || (tmr_cnt[TMR_STAB] != TMR_RST);
  assign test_mode_window = !started_q || (tmr_cnt[TMR_TEST] != TMR_RST);
  assign sda_oe           = oe_q;

  // Read mux; unmapped offsets read as zero
  always_comb begin
    case (ptr_q)
      ADDR_EVENT_FLAGS: rd_byte = flags_q;
      ADDR_PROX_FILT_H: rd_byte = filtered_count[15:8];
      ADDR_PROX_FILT_L: rd_byte = filtered_count[7:0];
      ADDR_PROX_REF_H:  rd_byte = long_average_reference[15:8];
      ADDR_PROX_REF_L:  rd_byte = long_average_reference[7:0];
      ADDR_QREL_REF_H:  rd_byte = quick_release_reference[15:8];
      ADDR_QREL_REF_L:  rd_byte = quick_release_reference[7:0];
      ADDR_MOT_FILT_H:  rd_byte = motion_filtered_count[15:8];
      ADDR_MOT_FILT_L:  rd_byte = motion_filtered_count[7:0];
      ADDR_MOT_UPPER_H: rd_byte = motion_upper_reference[15:8];
      ADDR_MOT_UPPER_L: rd_byte = motion_upper_reference[7:0];
      ADDR_MOT_LOWER_H: rd_byte = motion_lower_reference[15:8];
      ADDR_MOT_LOWER_L: rd_byte = motion_lower_reference[7:0];
      ADDR_PROX_RTY_H:  rd_byte = tmr_cnt[TMR_PROX][15:8];
      ADDR_PROX_RTY_L:  rd_byte = tmr_cnt[TMR_PROX][7:0];
      ADDR_MOT_RTY_H:   rd_byte = tmr_cnt[TMR_MOTION][15:8];
      ADDR_MOT_RTY_L:   rd_byte = tmr_cnt[TMR_MOTION][7:0];
      default:          rd_byte = BYTE_RST;
    endcase
  end

  // Bus conditions from sampled pins
  assign start_ev = scl_q && scl_in && sda_q && !sda_in;
  assign stop_ev  = scl_q && scl_in && !sda_q && sda_in;
  assign scl_rise = !scl_q && scl_in;
  assign scl_fall = scl_q && !scl_in;

  // Bus slave next state
  always_comb begin
    st_d    = st_q;
    bit_d   = bit_q;
    shift_d = shift_q;
    ptr_d   = ptr_q;
    first_d = first_q;
    rw_d    = rw_q;
    ack_d   = ack_q;
    clocked_d = clocked_q;
    oe_d    = oe_q;
    if (start_ev) begin
      st_d    = PSS_ADDR;
      bit_d   = 3'h0;
      oe_d    = 1'b0;
      first_d = 1'b1;
      clocked_d = 1'b0;
    end else if (stop_ev) begin
      st_d = PSS_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        PSS_IDLE: begin
          oe_d = 1'b0;
        end
        PSS_ADDR, PSS_WR_BYTE: begin
          // Sample on rise, act after the eighth bit's fall
          if (scl_rise) begin
            shift_d = {shift_q[6:0], sda_in};
            bit_d   = bit_q + 3'h1;
            clocked_d = 1'b1;
          // Guard stops the clock fall that closes a start from ending the byte
          end else if (scl_fall && (bit_q == 3'h0) && clocked_q) begin
            if (st_q == PSS_ADDR) begin
              rw_d = shift_q[0];
              oe_d = (shift_q[7:1] == DEV_ADDR);
              st_d = (shift_q[7:1] == DEV_ADDR) ? PSS_ADDR_ACK : PSS_IDLE;
            end else begin
              // Only the pointer byte is kept; data bytes are dropped
              if (first_q) begin
                ptr_d = shift_q;
              end
              first_d = 1'b0;
              oe_d    = 1'b1;
              st_d    = PSS_WR_ACK;
            end
          end
        end
        PSS_ADDR_ACK, PSS_RD_ACK: begin
          if (scl_rise) begin
            ack_d = !sda_in;
          end else if (scl_fall) begin
            if ((st_q == PSS_ADDR_ACK && rw_q) || (st_q == PSS_RD_ACK && ack_q)) begin
              shift_d = {rd_byte[6:0], 1'b0};
              oe_d    = !rd_byte[7];
              bit_d   = 3'h1;
              st_d    = PSS_RD_BYTE;
            end else if (st_q == PSS_ADDR_ACK) begin
              oe_d  = 1'b0;
              bit_d = 3'h0;
              st_d  = PSS_WR_BYTE;
            end else begin
              // Host nack ends the read
              oe_d = 1'b0;
              st_d = PSS_IDLE;
            end
          end
        end
        PSS_WR_ACK: begin
          if (scl_fall) begin
            oe_d  = 1'b0;
            bit_d = 3'h0;
            st_d  = PSS_WR_BYTE;
          end
        end
        PSS_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_q == 3'h0) begin
              oe_d  = 1'b0;
              ptr_d = ptr_q + 8'h01;
              st_d  = PSS_RD_ACK;
            end else begin
              oe_d    = !shift_q[7];
              shift_d = {shift_q[6:0], 1'b0};
              bit_d   = bit_q + 3'h1;
            end
          end
        end
        default: begin
          st_d = PSS_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  // Bus slave registers; pins idle high
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_q    <= PSS_IDLE;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      bit_q   <= 3'h0;
      shift_q <= BYTE_RST;
      ptr_q   <= BYTE_RST;
      first_q <= 1'b0;
      rw_q    <= 1'b0;
      ack_q   <= 1'b0;
      clocked_q <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      scl_q   <= scl_in;
      sda_q   <= sda_in;
      bit_q   <= bit_d;
      shift_q <= shift_d;
      ptr_q   <= ptr_d;
      first_q <= first_d;
      rw_q    <= rw_d;
      ack_q   <= ack_d;
      clocked_q <= clocked_d;
      oe_q    <= oe_d;
    end
  end

endmodule
`default_nettype wire

// file: design/pss_pkg.sv
package pss_pkg;

  // Clock and time base
  localparam int unsigned CLK_FREQ_HZ     = 125_000_000;  // Core clock rate
  localparam int unsigned MS_PER_S        = 1000;         // Milliseconds per second
  localparam int unsigned TICK_CYCLES     = CLK_FREQ_HZ / MS_PER_S;  // Cycles per 1 ms tick
  localparam int unsigned TICK_W          = 17;           // Width of the tick prescaler

  // Timer lengths, counted in 1 ms ticks
  localparam int unsigned CAL_RETRY_S     = 10;           // Calibration retry interval, s
  localparam int unsigned CAL_RETRY_MS    = CAL_RETRY_S * MS_PER_S;
  localparam int unsigned STAB_DEFAULT_MS = 340;          // Stabilise window, default rate
  localparam int unsigned STAB_FAST_MS    = 128;          // Stabilise window, fastest rate
  localparam int unsigned TEST_MODE_MS    = 340;          // Test-mode window after bus event
  localparam int unsigned TMR_W           = 16;           // Timer and readback width

  // Timer slots
  localparam int unsigned TMR_PROX        = 0;            // Proximity retry countdown
  localparam int unsigned TMR_MOTION      = 1;            // Movement retry countdown
  localparam int unsigned TMR_STAB        = 2;            // Start-up stabilisation
  localparam int unsigned TMR_TEST        = 3;            // Test-mode window
  localparam int unsigned TMR_NUM         = 4;

  // Serial bus device address, arbitrary value
  localparam logic [6:0] DEV_ADDR         = 7'h44;

  // Register offsets
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h14;
  localparam logic [7:0] ADDR_PROX_FILT_H = 8'h15;
  localparam logic [7:0] ADDR_PROX_FILT_L = 8'h16;
  localparam logic [7:0] ADDR_PROX_REF_H  = 8'h17;
  localparam logic [7:0] ADDR_PROX_REF_L  = 8'h18;
  localparam logic [7:0] ADDR_QREL_REF_H  = 8'h19;
  localparam logic [7:0] ADDR_QREL_REF_L  = 8'h1a;
  localparam logic [7:0] ADDR_MOT_FILT_H  = 8'h1b;
  localparam logic [7:0] ADDR_MOT_FILT_L  = 8'h1c;
  localparam logic [7:0] ADDR_MOT_UPPER_H = 8'h1d;
  localparam logic [7:0] ADDR_MOT_UPPER_L = 8'h1e;
  localparam logic [7:0] ADDR_MOT_LOWER_H = 8'h1f;
  localparam logic [7:0] ADDR_MOT_LOWER_L = 8'h20;
  localparam logic [7:0] ADDR_PROX_RTY_H  = 8'h23;
  localparam logic [7:0] ADDR_PROX_RTY_L  = 8'h24;
  localparam logic [7:0] ADDR_MOT_RTY_H   = 8'h25;
  localparam logic [7:0] ADDR_MOT_RTY_L   = 8'h26;

  // Event flag bit positions
  localparam int unsigned BIT_PROX        = 0;
  localparam int unsigned BIT_TOUCH       = 1;
  localparam int unsigned BIT_RAW         = 2;
  localparam int unsigned BIT_PROX_CAL    = 3;
  localparam int unsigned BIT_MOTION      = 4;
  localparam int unsigned BIT_MOTION_CAL  = 7;

  // Reset values
  localparam logic [7:0]  BYTE_RST        = 8'h00;
  localparam logic [15:0] TMR_RST         = 16'h0000;

  // Serial bus slave states
  typedef enum logic [2:0] {
    PSS_IDLE, PSS_ADDR, PSS_ADDR_ACK, PSS_WR_BYTE, PSS_WR_ACK, PSS_RD_BYTE, PSS_RD_ACK
  } pss_bus_state_t;

endpackage

// file: design/pss_countdown.sv
`timescale 1ns/1ns
`default_nettype none
module pss_countdown (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  // Control
  input  wire logic                      tick,
  input  wire logic                      load,
  input  wire logic [pss_pkg::TMR_W-1:0] load_val,
  // Status
  output logic      [pss_pkg::TMR_W-1:0] count_q,
  output logic                           expire_q
);
  import pss_pkg::*;

  logic [TMR_W-1:0] count_d;   // Next count
  logic             expire_d;  // Next expiry pulse

  // Load wins over counting so a restart is never lost
  always_comb begin
    count_d  = count_q;
    expire_d = 1'b0;
    if (load) begin
      count_d = load_val;
    end else if (tick && (count_q != TMR_RST)) begin
      count_d  = count_q - 16'h0001;
      expire_d = (count_q == 16'h0001);
    end
  end

  // Register stage
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      count_q  <= TMR_RST;
      expire_q <= 1'b0;
    end else begin
      count_q  <= count_d;
      expire_q <= expire_d;
    end
  end

endmodule
`default_nettype wire

// file: tb/pss_status_checker.sv
`timescale 1ns/1ns
`default_nettype none
module pss_status_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe,
  // Engine side
  input wire logic prox_detect,
  input wire logic prox_cal_fail,
  input wire logic prox_cal_pass,
  input wire logic motion_cal_fail,
  // Device outputs
  input wire logic prox_out_oe,
  input wire logic prox_cal_retry,
  input wire logic motion_cal_retry,
  input wire logic stabilizing,
  input wire logic test_mode_window
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic err_q;  // Proximity error seen
  logic err_d;  // Its next value
  // A fail wins over a pass in the same cycle
  always_comb err_d = prox_cal_fail | (err_q & ~prox_cal_pass);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) err_q <= 1'b0;
    else err_q <= err_d;
  end
  // Start: data falls while the bus clock stays high
  sequence bus_start_s;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  // Failure with no pass in the same cycle
  sequence fail_s;
    prox_cal_fail && !prox_cal_pass;
  endsequence
  prox_follow_a: assert property (!stabilizing && prox_detect |=> prox_out_oe)
    else $error("output not active after detection");
  stab_mask_a: assert property (stabilizing && $past(stabilizing, 2) && !err_q
    && !$past(err_q, 2) |-> !prox_out_oe)
    else $error("detection reported while stabilizing");
  fail_oe_a: assert property (prox_cal_fail |=> prox_out_oe)
    else $error("output not forced on calibration error");
  retry_hold_a: assert property (fail_s |=> !prox_cal_retry [*8])
    else $error("proximity retry too early");
  motion_hold_a: assert property (motion_cal_fail |=> !motion_cal_retry [*8])
    else $error("movement retry too early");
  retry_pulse_a: assert property (prox_cal_retry |=> !prox_cal_retry)
    else $error("retry request longer than one cycle");
  test_win_a: assert property (bus_start_s |-> ##3 test_mode_window [*8])
    else $error("test window not restarted by start");
  sda_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data pull changed while bus clock high");
endmodule
`default_nettype wire

// file: tb/pss_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module pss_host_model (
  // Clock
  input  wire logic clock,
  // Bus pins, data is pulled low only
  output logic      scl_pin,
  output logic      sda_pull,
  input  wire logic sda_line,
  // Device status
  input  wire logic test_mode_window
);
  import pss_pkg::*;
  localparam int Q = 4;  // Clocks per quarter bit, keeps edges four clocks apart
  logic [7:0] rd_q[$];   // Bytes read back
  // Idle bus: both lines released
  initial begin
    scl_pin = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic qw();
    repeat (Q) @(posedge clock);
  endtask
  // One bit slot; a released line reads back the device
  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    qw();
    scl_pin <= 1'b1;
    qw();
    r = sda_line;
    qw();
    scl_pin <= 1'b0;
    qw();
  endtask
  // Start or repeated start
  task automatic start_c();
    sda_pull <= 1'b0;
    qw();
    scl_pin <= 1'b1;
    qw();
    sda_pull <= 1'b1;
    qw();
    scl_pin <= 1'b0;
    qw();
  endtask
  task automatic stop_c();
    sda_pull <= 1'b1;
    qw();
    scl_pin <= 1'b1;
    qw();
    sda_pull <= 1'b0;
    qw();
  endtask
  task automatic byte_io(input logic [7:0] w, input logic a, output logic [7:0] r);
    logic k;
    for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
    bit_io(a, k);
  endtask
  // Pointer write, then one data byte or a burst of n reads, last one refused
  task automatic txn(input logic [7:0] ptr, input logic rd, input logic [7:0] wd, input int n);
    logic [7:0] r;
    int lim;
    lim = 0;
    // Stay quiet while the test window runs
    while (test_mode_window !== 1'b0 && lim < 5000) begin
      @(posedge clock);
      lim++;
    end
    start_c();
    byte_io({DEV_ADDR, 1'b0}, 1'b1, r);
    byte_io(ptr, 1'b1, r);
    if (!rd) byte_io(wd, 1'b1, r);
    else begin
      start_c();
      byte_io({DEV_ADDR, 1'b1}, 1'b1, r);
      for (int i = 0; i < n; i++) begin
        byte_io(8'hff, i == n - 1, r);
        rd_q.push_back(r);
      end
    end
    stop_c();
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pss_pkg::*;
  localparam int TK = 4;  // Cycles per ms, shortened so timers fit the run
  logic        clock, sys_rst, fast_rate;                  // Clock, reset, rate
  logic        prox_detect, touch_detect, prox_raw_detect, motion_detect;
  logic        prox_cal_fail, prox_cal_pass, motion_cal_fail, motion_cal_pass;
  logic [15:0] cnt [6];                                    // Engine counts
  logic        sda_oe, prox_out_oe, prox_cal_retry, motion_cal_retry;
  logic        stabilizing, test_mode_window, scl, sda_pull;
  int          n_fail, checks_done, cyc;
  wire logic   sda_line = ~(sda_oe | sda_pull);            // Wired-AND, pulled up
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial cyc = 0;
  always @(posedge clock) cyc <= cyc + 1;
  pss_status_regs #(.TICK_CYCLES_P(TK)) i_pss_status_regs (
    .clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line), .sda_oe(sda_oe),
    .prox_detect(prox_detect), .touch_detect(touch_detect),
    .prox_raw_detect(prox_raw_detect), .motion_detect(motion_detect), .fast_rate(fast_rate),
    .prox_cal_fail(prox_cal_fail), .prox_cal_pass(prox_cal_pass),
    .motion_cal_fail(motion_cal_fail), .motion_cal_pass(motion_cal_pass),
    .filtered_count(cnt[0]), .long_average_reference(cnt[1]),
    .quick_release_reference(cnt[2]), .motion_filtered_count(cnt[3]),
    .motion_upper_reference(cnt[4]), .motion_lower_reference(cnt[5]),
    .prox_out_oe(prox_out_oe), .prox_cal_retry(prox_cal_retry),
    .motion_cal_retry(motion_cal_retry), .stabilizing(stabilizing),
    .test_mode_window(test_mode_window));
  pss_host_model i_host (
    .clock(clock), .scl_pin(scl), .sda_pull(sda_pull), .sda_line(sda_line),
    .test_mode_window(test_mode_window));
  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Counts and cycle spans within a window
  task automatic check_in(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Reset, then time the stabilising window
  task automatic do_reset(input logic fr, input int ms);
    int n;
    // Raise reset on a rising edge like every other input
    @(posedge clock);
    sys_rst <= 1'b1;
    fast_rate <= fr;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    n = 0;
    @(negedge clock);
    while (stabilizing === 1'b1 && n < 5000) begin
      @(negedge clock);
      n++;
    end
    check_in(n, ms * TK - 8, ms * TK + 8);
  endtask
  // Burst 0x14..0x26: flags, six counts hi then lo, two unmapped, two countdowns
  task automatic read_all(input logic [7:0] fl, input logic cal);
    logic [7:0] q[$];
    int cd;
    for (int i = 0; i < 6; i++) begin
      q.push_back(cnt[i][15:8]);
      q.push_back(cnt[i][7:0]);
    end
    q.push_back(8'h00);
    q.push_back(8'h00);
    i_host.rd_q.delete();
    i_host.txn(ADDR_EVENT_FLAGS, 1'b1, 8'h00, 19);
    check_eq(i_host.rd_q[0], fl);
    for (int i = 1; i < 15; i++) begin
      check_eq(i_host.rd_q[i], q[i - 1]);
    end
    for (int i = 15; i < 19; i += 2) begin
      cd = {i_host.rd_q[i], i_host.rd_q[i + 1]};
      check_in(cd, cal ? 1 : 0, cal ? CAL_RETRY_MS : 0);
    end
  endtask
  initial begin
    int unsigned v;
    int t0, tp, tm;
    sys_rst = 1'b1;
    fast_rate = 1'b1;
    {prox_detect, touch_detect, prox_raw_detect, motion_detect} = 4'hf;
    {prox_cal_fail, prox_cal_pass, motion_cal_fail, motion_cal_pass} = 4'h0;
    foreach (cnt[i]) cnt[i] = 16'h0000;
    n_fail = 0;
    checks_done = 0;
    v = $urandom(32'h9496_4f41);
    do_reset(1'b1, STAB_FAST_MS);
    do_reset(1'b0, STAB_DEFAULT_MS);
    // Random levels; a host write first must leave every value alone
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      foreach (cnt[i]) cnt[i] <= 16'($urandom_range(2000));
      {prox_detect, touch_detect, prox_raw_detect, motion_detect} <= 4'($urandom);
      @(posedge clock);
      i_host.txn(8'($urandom_range(8'h20, 8'h14)), 1'b0, 8'($urandom), 0);
      read_all({3'h0, motion_detect, 1'b0, prox_raw_detect, touch_detect, prox_detect},
               1'b0);
      check_eq(prox_out_oe, prox_detect);
    end
    // Both calibrations fail with nothing detected
    {prox_detect, touch_detect, prox_raw_detect, motion_detect} <= 4'h0;
    prox_cal_fail <= 1'b1;
    motion_cal_fail <= 1'b1;
    @(posedge clock);
    t0 = cyc;
    prox_cal_fail <= 1'b0;
    motion_cal_fail <= 1'b0;
    read_all(8'h88, 1'b1);
    check_eq(prox_out_oe, 1'b1);
    tp = 0;
    tm = 0;
    while ((tp == 0 || tm == 0) && cyc - t0 < 45000) begin
      @(negedge clock);
      if (prox_cal_retry === 1'b1) tp = cyc - t0;
      if (motion_cal_retry === 1'b1) tm = cyc - t0;
    end
    check_in(tp, CAL_RETRY_MS * TK - 8, CAL_RETRY_MS * TK + 8);
    check_in(tm, CAL_RETRY_MS * TK - 8, CAL_RETRY_MS * TK + 8);
    @(posedge clock);
    prox_cal_pass <= 1'b1;
    motion_cal_pass <= 1'b1;
    @(posedge clock);
    prox_cal_pass <= 1'b0;
    motion_cal_pass <= 1'b0;
    read_all(8'h00, 1'b0);
    check_eq(prox_out_oe, 1'b0);
    final_report();
  end
  // Cut a hang short
  initial begin
    repeat (90000) @(posedge clock);
    n_fail++;
    final_report();
  end
endmodule
bind pss_status_regs pss_status_checker i_chk (
  .clock(clock), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
  .prox_detect(prox_detect), .prox_cal_fail(prox_cal_fail), .prox_cal_pass(prox_cal_pass),
  .motion_cal_fail(motion_cal_fail), .prox_out_oe(prox_out_oe),
  .prox_cal_retry(prox_cal_retry), .motion_cal_retry(motion_cal_retry),
  .stabilizing(stabilizing), .test_mode_window(test_mode_window));
`default_nettype wire
